// file: src/eib_top.sv
// Purpose: External request front end, key-sense merge and address break unit
// Assumes: Classic Wishbone slave, all inputs synchronous to clk_i
// Notes:   Vector output follows fixed priority: nonmaskable, lines 0..7, break
//
// Function
// - Mask bit 0 lets its key-sense input request; 1 blocks it.
// - Key-sense mask loads BF on reset and hardware standby.
// - Key-sense inputs share request six: sense, enable, flag.
// - Match flag sets when break address is prefetched with break enable.
// - Match flag clears on break exception handling; software cannot write it.
// - Break request is raised while match flag and break enable are set.
// - Control bit 0 is break enable, read/write.
// - Control bits 6..1 and low address bit 0 read zero, ignore writes.
// - Break registers clear on reset/hardware standby, keep through software standby.
// - Break address held high 23..16, mid 15..8, low 7..1.
// - Address bits 15..1 compare with internal bus bits 15..1.
// - Normal mode excludes address bits 23..16 from comparison.
// - Nonmaskable request has top priority and is always accepted.
// - Edge select bit picks rising or falling nonmaskable trigger.
// - Nonmaskable exception uses vector 7.
// - External requests seven down to zero use vectors 23 down to 16.
// - Request flags set on their condition even when disabled.
// - Detection works whatever the pin direction.
// - Nonmaskable and lines 7,6,2,1,0 wake from software standby.
// - Transfer-controller activation ignores mode and processor mask.
// - Sense bits: 00 low, 01 falling, 10 rising, 11 both edges.
// - Flag clears by writing 0 after reading 1; writing 1 does nothing.
// - Enable bit 1 enables its line; register resets to zero.
`timescale 1ns/1ps
`default_nettype none
module eib_top
  import eib_pkg::*;
#(
  parameter int LINES = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             hw_standby_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Pins
  input  wire logic             nmi_i,
  input  wire logic [LINES-1:0] req_n_i,
  input  wire logic [7:0]       key_sense_n_i,
  // CPU side
  input  wire logic             normal_mode_i,
  input  wire logic [23:0]      cpu_addr_i,
  input  wire logic             prefetch_i,
  input  wire logic             exc_ack_i,
  input  wire logic [7:0]       exc_vector_i,
  // Requests
  output logic                  vec_valid_o,
  output logic      [7:0]       vec_o,
  output logic      [LINES-1:0] req_o,
  output logic      [LINES-1:0] xfer_req_o,
  output logic                  break_req_o,
  output logic                  wake_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]         key_mask_q;
  logic               cmf_q;
  logic               bie_q;
  logic [7:0]         brk_high_q;
  logic [7:0]         brk_mid_q;
  logic [7:1]         brk_low_q;
  logic [15:0]        sense_q;
  logic [LINES-1:0]   enable_q;
  logic [LINES-1:0]   flag_q;
  logic [LINES-1:0]   flag_d;
  logic [LINES-1:0]   seen_q;
  logic               nmi_edge_sel_q;
  logic               nmi_prev_q;
  logic               nmi_pend_q;
  logic               nmi_pend_d;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        init      = rst_i | hw_standby_i;
  wire        access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr        = access & wb_we_i & wb_sel_i[0];
  wire        wr_hi     = access & wb_we_i & wb_sel_i[1];
  wire        rd        = access & ~wb_we_i;
  wire        hit_mask  = wb_adr_i == OFS_KEY_MASK;
  wire        hit_ctl   = wb_adr_i == OFS_BRK_CTL;
  wire        hit_high  = wb_adr_i == OFS_BRK_HIGH;
  wire        hit_mid   = wb_adr_i == OFS_BRK_MID;
  wire        hit_low   = wb_adr_i == OFS_BRK_LOW;
  wire        hit_sense = wb_adr_i == OFS_SENSE_CTL;
  wire        hit_en    = wb_adr_i == OFS_REQ_ENABLE;
  wire        hit_flag  = wb_adr_i == OFS_REQ_FLAG;
  wire        hit_sys   = wb_adr_i == OFS_SYS_CTL;

  // Reserved bits read zero, unmapped offsets read zero
  wire [31:0] rd_data =
      hit_mask  ? {24'h000000, key_mask_q} :
      hit_ctl   ? {24'h000000, cmf_q, 6'h00, bie_q} :
      hit_high  ? {24'h000000, brk_high_q} :
      hit_mid   ? {24'h000000, brk_mid_q} :
      hit_low   ? {24'h000000, brk_low_q, 1'b0} :
      hit_sense ? {16'h0000, sense_q} :
      hit_en    ? {24'h000000, enable_q} :
      hit_flag  ? {24'h000000, flag_q} :
      hit_sys   ? {31'h00000000, nmi_edge_sel_q} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= rd ? rd_data : 32'h00000000;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Hardware standby acts as reset; software standby keeps contents
  always_ff @(posedge clk_i) begin
    if (init) begin
      key_mask_q     <= KEY_MASK_RST;
      bie_q          <= BRK_RST[BRK_BIE_BIT];
      brk_high_q     <= BRK_RST;
      brk_mid_q      <= BRK_RST;
      brk_low_q      <= BRK_RST[7:1];
      sense_q        <= SENSE_CTL_RST;
      enable_q       <= REQ_ENABLE_RST;
      nmi_edge_sel_q <= SYS_CTL_RST;
    end else begin
      if (wr && hit_mask) begin
        key_mask_q <= wb_dat_i[7:0];
      end
      if (wr && hit_ctl) begin
        bie_q <= wb_dat_i[BRK_BIE_BIT];
      end
      if (wr && hit_high) begin
        brk_high_q <= wb_dat_i[7:0];
      end
      if (wr && hit_mid) begin
        brk_mid_q <= wb_dat_i[7:0];
      end
      if (wr && hit_low) begin
        brk_low_q <= wb_dat_i[7:1];
      end
      if (wr && hit_sense) begin
        sense_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_hi && hit_sense) begin
        sense_q[15:8] <= wb_dat_i[15:8];
      end
      if (wr && hit_en) begin
        enable_q <= wb_dat_i[LINES-1:0];
      end
      if (wr && hit_sys) begin
        nmi_edge_sel_q <= wb_dat_i[NMI_EDGE_BIT];
      end
    end
  end

  // ****************************************
  // Key-sense merge and request detection
  // ****************************************
  // Wired-AND style merge keeps line six usable alongside its own pin
  wire              key_low = |(~key_sense_n_i & ~key_mask_q);
  wire [LINES-1:0]  pin_n;
  wire [LINES-1:0]  ev;

  // Pins are read straight, so output-mode pins still trigger
  assign pin_n = req_n_i & ~(LINES'(key_low) << KEY_REQ_LINE);

  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_sense
      eib_sense u_sense (
        .clk_i   (clk_i),
        .rst_i   (init),
        .pin_n_i (pin_n[gi]),
        .sense_i (sense_q[2*gi +: 2]),
        .event_o (ev[gi])
      );
    end
  endgenerate

  // ****************************************
  // Request flags
  // ****************************************
  wire             exc_req  = exc_ack_i && exc_vector_i >= VEC_REQ_BASE
                              && exc_vector_i < VEC_REQ_BASE + 8'(LINES);
  wire [7:0]       exc_line = exc_vector_i - VEC_REQ_BASE;
  wire [LINES-1:0] sw_clr   = (wr && hit_flag) ? (seen_q & ~wb_dat_i[LINES-1:0])
                                               : '0;

  // Level-sensed flags stay while the pin holds low; edge flags clear on service
  always_comb begin
    flag_d = flag_q & ~sw_clr;
    for (int i = 0; i < LINES; i++) begin
      if (exc_req && exc_line == 8'(i)
          && (sense_q[2*i +: 2] != SENSE_LOW || pin_n[i])) begin
        flag_d[i] = 1'b0;
      end
    end
    flag_d = flag_d | ev;
  end

  // Only a read that returned 1 arms the write-0 clear
  always_ff @(posedge clk_i) begin
    if (init) begin
      flag_q <= REQ_FLAG_RST;
      seen_q <= '0;
    end else begin
      flag_q <= flag_d;
      if (rd && hit_flag) begin
        seen_q <= flag_q;
      end else if (wr && hit_flag) begin
        seen_q <= '0;
      end
    end
  end

  // ****************************************
  // Nonmaskable request
  // ****************************************
  wire nmi_edge = nmi_edge_sel_q ? (~nmi_prev_q & nmi_i)
                                 : (nmi_prev_q & ~nmi_i);

  // A new edge in the service cycle is kept, not lost
  assign nmi_pend_d = nmi_edge | (nmi_pend_q & ~(exc_ack_i && exc_vector_i == VEC_NMI));

  always_ff @(posedge clk_i) begin
    if (init) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_i;
      nmi_pend_q <= nmi_pend_d;
    end
  end

  // ****************************************
  // Address break
  // ****************************************
  wire lo_match  = cpu_addr_i[15:1] == {brk_mid_q, brk_low_q};
  wire hi_match  = normal_mode_i || cpu_addr_i[23:16] == brk_high_q;
  wire brk_hit   = prefetch_i & bie_q & lo_match & hi_match;
  wire brk_serv  = exc_ack_i && exc_vector_i == VEC_BREAK;

  // Software writes never reach the flag; a hit in the service cycle wins
  always_ff @(posedge clk_i) begin
    if (init) begin
      cmf_q <= BRK_RST[BRK_CMF_BIT];
    end else begin
      cmf_q <= brk_hit | (cmf_q & ~brk_serv);
    end
  end

  // ****************************************
  // Request outputs
  // ****************************************
  wire [LINES-1:0] active = flag_q & enable_q;
  logic [7:0]      vec_sel;
  logic            vec_any;

  // Fixed priority; there is no mask input, so the top source is always offered
  always_comb begin
    vec_any = 1'b1;
    vec_sel = VEC_NMI;
    if (!nmi_pend_q) begin
      vec_any = 1'b0;
      for (int i = LINES - 1; i >= 0; i--) begin
        if (active[i]) begin
          vec_any = 1'b1;
          vec_sel = VEC_REQ_BASE + 8'(i);
        end
      end
      if (!vec_any && cmf_q && bie_q) begin
        vec_any = 1'b1;
        vec_sel = VEC_BREAK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      vec_valid_o <= 1'b0;
      vec_o       <= 8'h00;
      req_o       <= '0;
      xfer_req_o  <= '0;
      break_req_o <= 1'b0;
      wake_o      <= 1'b0;
    end else begin
      vec_valid_o <= vec_any;
      vec_o       <= vec_any ? vec_sel : 8'h00;
      req_o       <= active;
      xfer_req_o  <= active;
      break_req_o <= cmf_q & bie_q;
      wake_o      <= nmi_pend_q | (|(flag_q & WAKE_LINES[LINES-1:0]));
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_mask_reset: assert property (@(posedge clk_i) init |=> key_mask_q == KEY_MASK_RST)
    else $error("key mask not BF after reset");
  a_break_request: assert property (@(posedge clk_i) disable iff (init)
    (cmf_q && bie_q) |=> break_req_o)
    else $error("break request missing");
  a_match_set: assert property (@(posedge clk_i) disable iff (init)
    brk_hit |=> cmf_q)
    else $error("match flag not set on hit");
  a_match_clear: assert property (@(posedge clk_i) disable iff (init)
    (brk_serv && !brk_hit) |=> !cmf_q)
    else $error("match flag not cleared by service");
  a_nmi_vector: assert property (@(posedge clk_i) disable iff (init)
    nmi_pend_q |=> vec_valid_o && vec_o == 8'h07)
    else $error("nonmaskable vector wrong");
  a_flag_sets: assert property (@(posedge clk_i) disable iff (init)
    ev[0] |=> flag_q[0])
    else $error("flag zero not set");
  a_high_ignored: assert property (@(posedge clk_i) disable iff (init)
    (normal_mode_i && prefetch_i && bie_q && lo_match) |=> cmf_q)
    else $error("high bits compared in normal mode");
  a_wake_lines: assert property (@(posedge clk_i) disable iff (init)
    (!nmi_pend_q && (flag_q & WAKE_LINES[LINES-1:0]) == '0) |=> !wake_o)
    else $error("wake from non-wake line");
  a_key_merge: assert property (@(posedge clk_i) disable iff (init)
    (key_low && sense_q[13:12] == SENSE_LOW) |=> flag_q[KEY_REQ_LINE])
    else $error("key-sense low did not set line six");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  c_break_hit: cover property (@(posedge clk_i) disable iff (init) brk_hit ##1 break_req_o);
  c_key_flag: cover property (@(posedge clk_i) disable iff (init) key_low ##1 flag_q[6]);
  c_sw_clear: cover property (@(posedge clk_i) disable iff (init) sw_clr != '0);
  c_nmi_serv: cover property (@(posedge clk_i) disable iff (init) nmi_pend_q ##[1:20] !nmi_pend_q);

endmodule // eib_top
`default_nettype wire

// file: src/eib_pkg.sv
// Purpose: Shared constants of the external interrupt and address break block
// Assumes: Byte offsets on a 32-bit classic Wishbone slave, 8-bit registers except the 16-bit sense control
// Notes:   Offsets are word aligned; narrower registers sit in the low bits
package eib_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_KEY_MASK   = 8'h00;
  localparam logic [7:0] OFS_BRK_CTL    = 8'h04;
  localparam logic [7:0] OFS_BRK_HIGH   = 8'h08;
  localparam logic [7:0] OFS_BRK_MID    = 8'h0C;
  localparam logic [7:0] OFS_BRK_LOW    = 8'h10;
  localparam logic [7:0] OFS_SENSE_CTL  = 8'h14;
  localparam logic [7:0] OFS_REQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_REQ_FLAG   = 8'h1C;
  localparam logic [7:0] OFS_SYS_CTL    = 8'h20;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  KEY_MASK_RST   = 8'hBF;
  localparam logic [7:0]  BRK_RST        = 8'h00;
  localparam logic [15:0] SENSE_CTL_RST  = 16'h0000;
  localparam logic [7:0]  REQ_ENABLE_RST = 8'h00;
  localparam logic [7:0]  REQ_FLAG_RST   = 8'h00;
  localparam logic        SYS_CTL_RST    = 1'b0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BRK_CMF_BIT = 7;
  localparam int BRK_BIE_BIT = 0;
  localparam int NMI_EDGE_BIT = 0;
  localparam int KEY_REQ_LINE = 6;

  // ****************************************
  // Sense encodings and vectors
  // ****************************************
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  localparam logic [7:0] VEC_NMI      = 8'h07;
  localparam logic [7:0] VEC_REQ_BASE = 8'h10;
  localparam logic [7:0] VEC_BREAK    = 8'h1B;

  // Lines able to leave software standby
  localparam logic [7:0] WAKE_LINES = 8'hC7;

endpackage

// file: src/eib_sense.sv
// Purpose: Trigger detector for one external request pin
// Assumes: Pin is synchronous to clk_i and active low
// Notes:   Level mode fires every cycle the pin stays low
`timescale 1ns/1ps
`default_nettype none
module eib_sense
  import eib_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pin and mode
  input  wire logic       pin_n_i,
  input  wire logic [1:0] sense_i,
  // Detected trigger
  output logic            event_o
);

  logic prev_q;
  logic fall;
  logic rise;

  // Idle pin is high, so no edge is seen just after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= pin_n_i;
    end
  end

  assign fall = prev_q & ~pin_n_i;
  assign rise = ~prev_q & pin_n_i;

  always_comb begin
    case (sense_i)
      SENSE_LOW:  event_o = ~pin_n_i;
      SENSE_FALL: event_o = fall;
      SENSE_RISE: event_o = rise;
      SENSE_BOTH: event_o = fall | rise;
      default:    event_o = 1'b0;
    endcase
  end

endmodule // eib_sense
`default_nettype wire

// file: tb/eib_cpu_model.sv
// Purpose: CPU core, key matrix and request pin model facing the block
// Assumes: Bench calls one task at a time, each starting on a clock edge
// Notes:   Idle address bus shows the inverse of the last address
`timescale 1ns/1ps
`default_nettype none
module eib_cpu_model (
  // Clock
  input  wire logic        clk_i,
  // Pins
  output logic             nmi_o,
  output logic [7:0]       req_n_o,
  output logic [7:0]       key_n_o,
  // Bus side
  output logic             normal_mode_o,
  output logic [23:0]      addr_o,
  output logic             prefetch_o,
  output logic             exc_ack_o,
  output logic [7:0]       exc_vector_o
);
  initial begin
    nmi_o = 1'b1;
    req_n_o = 8'hFF;
    key_n_o = 8'hFF;
    normal_mode_o = 1'b1;
    addr_o = 24'h000000;
    prefetch_o = 1'b0;
    exc_ack_o = 1'b0;
    exc_vector_o = 8'h00;
  end

  // ****************************************
  // Pin and bus activity
  // ****************************************
  task automatic pins(input logic n, input logic [7:0] r, input logic [7:0] k);
    @(posedge clk_i);
    nmi_o <= n;
    req_n_o <= r;
    key_n_o <= k;
  endtask

  task automatic mode(input logic m);
    @(posedge clk_i);
    normal_mode_o <= m;
  endtask

  // Only first instruction bytes are fetched as break targets
  task automatic fetch(input logic [23:0] a);
    @(posedge clk_i);
    addr_o <= a;
    prefetch_o <= 1'b1;
    @(posedge clk_i);
    prefetch_o <= 1'b0;
    addr_o <= ~a;
  endtask

  task automatic take(input logic [7:0] v);
    @(posedge clk_i);
    exc_ack_o <= 1'b1;
    exc_vector_o <= v;
    @(posedge clk_i);
    exc_ack_o <= 1'b0;
    exc_vector_o <= ~v;
  endtask
endmodule // eib_cpu_model
`default_nettype wire

// file: tb/eib_top_tb_top.sv
// Purpose: Self-checking bench for the request front end and break unit
// Assumes: Wishbone answers in one cycle; pin effects show 2 cycles later
// Notes:   Waits of 3 cycles leave one edge of margin after a pin task
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module eib_top_tb_top;
  import eib_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hw_standby = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        nmi, prefetch, exc_ack, normal_mode;
  logic [7:0]  req_n, key_n, exc_vector, vec_o, req_o, xfer_req_o;
  logic [23:0] cpu_addr;
  logic        vec_valid_o, break_req_o, wake_o;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [3:0]  lo_hit = 4'b1011;
  logic [3:0]  hi_hit = 4'b1101;

  always #50 clk_i = ~clk_i;

  eib_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hw_standby),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .nmi_i(nmi), .req_n_i(req_n), .key_sense_n_i(key_n), .normal_mode_i(normal_mode),
    .cpu_addr_i(cpu_addr), .prefetch_i(prefetch), .exc_ack_i(exc_ack),
    .exc_vector_i(exc_vector), .vec_valid_o(vec_valid_o), .vec_o(vec_o), .req_o(req_o),
    .xfer_req_o(xfer_req_o), .break_req_o(break_req_o), .wake_o(wake_o));

  eib_cpu_model u_cpu (.clk_i(clk_i), .nmi_o(nmi), .req_n_o(req_n), .key_n_o(key_n),
    .normal_mode_o(normal_mode), .addr_o(cpu_addr), .prefetch_o(prefetch),
    .exc_ack_o(exc_ack), .exc_vector_o(exc_vector));

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hF;
    wb_adr <= a;
    wb_dat <= d;
    // Only the bench timeout ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_sel <= 4'h0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    `CHK("register read", e, q)
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    tick(6);
    rst_i <= 1'b0;
    tick(1);
    rd(OFS_KEY_MASK, 32'h000000BF);
    rd(OFS_BRK_CTL, 32'h00000000);
    rd(OFS_BRK_HIGH, 32'h00000000);
    rd(OFS_BRK_LOW, 32'h00000000);
    rd(OFS_REQ_ENABLE, 32'h00000000);
    $display("test reset values done");
    wr(OFS_BRK_CTL, 32'h000000FF);
    rd(OFS_BRK_CTL, 32'h00000001);
    wr(OFS_BRK_LOW, 32'h000000FF);
    rd(OFS_BRK_LOW, 32'h000000FE);
    rd(8'h3C, 32'h00000000);
    wr(OFS_BRK_HIGH, 32'h00000012);
    wr(OFS_BRK_MID, 32'h00000034);
    wr(OFS_BRK_LOW, 32'h00000056);
    u_cpu.fetch(24'hAB3457);
    tick(2);
    `CHK("break request", 1'b1, break_req_o)
    `CHK("vector", VEC_BREAK, vec_o)
    rd(OFS_BRK_CTL, 32'h00000081);
    wr(OFS_BRK_CTL, 32'h00000000);
    `CHK("break request", 1'b0, break_req_o)
    rd(OFS_BRK_CTL, 32'h00000080);
    wr(OFS_BRK_CTL, 32'h00000001);
    u_cpu.take(VEC_BREAK);
    tick(2);
    rd(OFS_BRK_CTL, 32'h00000001);
    u_cpu.mode(1'b0);
    u_cpu.fetch(24'hAB3456);
    tick(2);
    `CHK("break request", 1'b0, break_req_o)
    u_cpu.fetch(24'h123456);
    tick(2);
    `CHK("break request", 1'b1, break_req_o)
    u_cpu.take(VEC_BREAK);
    u_cpu.mode(1'b1);
    $display("test address break done");
    for (int m = 0; m < 4; m++) begin
      wr(OFS_SENSE_CTL, 32'(m) << 6);
      u_cpu.pins(1'b1, 8'hF7, 8'hFF);
      tick(3);
      `CHK("request out", 8'h00, req_o)
      `CHK("wake", 1'b0, wake_o)
      rd(OFS_REQ_FLAG, {28'h0, lo_hit[m], 3'h0});
      wr(OFS_REQ_FLAG, 32'h00000000);
      u_cpu.pins(1'b1, 8'hFF, 8'hFF);
      tick(3);
      rd(OFS_REQ_FLAG, {28'h0, hi_hit[m], 3'h0});
      wr(OFS_REQ_FLAG, 32'h00000000);
    end
    wr(OFS_REQ_FLAG, 32'h000000FF);
    rd(OFS_REQ_FLAG, 32'h00000000);
    $display("test sense modes done");
    wr(OFS_REQ_ENABLE, 32'h00000008);
    wr(OFS_SENSE_CTL, 32'h00000040);
    u_cpu.pins(1'b1, 8'hF7, 8'hFF);
    tick(3);
    `CHK("request out", 8'h08, req_o)
    `CHK("transfer request", 8'h08, xfer_req_o)
    `CHK("vector", VEC_REQ_BASE + 8'h03, vec_o)
    u_cpu.pins(1'b0, 8'hF7, 8'hFF);
    tick(3);
    `CHK("vector", VEC_NMI, vec_o)
    `CHK("pending", 1'b1, vec_valid_o)
    `CHK("wake", 1'b1, wake_o)
    u_cpu.take(VEC_NMI);
    u_cpu.take(VEC_REQ_BASE + 8'h03);
    tick(2);
    `CHK("request out", 8'h00, req_o)
    `CHK("pending", 1'b0, vec_valid_o)
    wr(OFS_SYS_CTL, 32'h00000001);
    u_cpu.pins(1'b1, 8'hFF, 8'hFF);
    tick(3);
    `CHK("vector", VEC_NMI, vec_o)
    u_cpu.take(VEC_NMI);
    $display("test vectors done");
    wr(OFS_SENSE_CTL, 32'h00000000);
    u_cpu.pins(1'b1, 8'h7F, 8'hFF);
    tick(3);
    `CHK("wake", 1'b1, wake_o)
    u_cpu.pins(1'b1, 8'hFF, 8'hFF);
    rd(OFS_REQ_FLAG, 32'h00000080);
    wr(OFS_REQ_FLAG, 32'h00000000);
    $display("test wake done");
    wr(OFS_REQ_ENABLE, 32'h00000040);
    u_cpu.pins(1'b1, 8'hFF, 8'hFE); // Line six stays in low-level sense
    tick(3);
    `CHK("request out", 8'h00, req_o)
    u_cpu.pins(1'b1, 8'hFF, 8'hBF);
    tick(3);
    `CHK("request out", 8'h40, req_o)
    `CHK("vector", VEC_REQ_BASE + 8'h06, vec_o)
    u_cpu.pins(1'b1, 8'hFF, 8'hFF);
    rd(OFS_REQ_FLAG, 32'h00000040);
    wr(OFS_REQ_FLAG, 32'h00000000);
    wr(OFS_KEY_MASK, 32'h000000FE);
    u_cpu.pins(1'b1, 8'hFF, 8'hFE);
    tick(3);
    rd(OFS_REQ_FLAG, 32'h00000040);
    u_cpu.pins(1'b1, 8'hFF, 8'hFF);
    wr(OFS_REQ_FLAG, 32'h00000000);
    $display("test key sense done");
    hw_standby <= 1'b1;
    tick(2);
    hw_standby <= 1'b0;
    tick(1);
    rd(OFS_KEY_MASK, 32'h000000BF);
    rd(OFS_BRK_MID, 32'h00000000);
    $display("test standby done");
    tally_and_finish();
  end
endmodule // eib_top_tb_top
`default_nettype wire
